// >>> i2c_ctrl_pkg.sv
package i2c_ctrl_pkg;

   // ***********************************************
   // Bus addressing
   // ***********************************************
   localparam logic [6:0] TARGET_ADDR      = 7'h18;
   localparam logic [6:0] GENERAL_CALL     = 7'h00;
   localparam int         BITS_PER_BYTE    = 8;
   localparam logic [3:0] ACK_SLOT         = 4'h8;

   // ***********************************************
   // Register file shape and reset values
   // ***********************************************
   localparam int         REG_ADDR_W       = 7;
   localparam int         REG_COUNT        = 128;
   localparam logic [6:0] GC_CTRL_REG      = 7'h22;
   localparam int         GC_ENABLE_BIT    = 5;
   localparam logic [7:0] REG_RESET        = 8'h00;
   localparam logic [6:0] PTR_RESET        = 7'h00;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int         SYNC_STAGES      = 2;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WRITE,
      ST_WRITE_ACK,
      ST_READ,
      ST_READ_ACK,
      ST_IGNORE
   } slave_state_e;

endpackage : i2c_ctrl_pkg

// >>> pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pin_sync
   import i2c_ctrl_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   // ***********************************************
   // Two-flop synchroniser, lines idle high
   // ***********************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         stage_one <= '1;
         sync_out  <= '1;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end

endmodule : pin_sync

`default_nettype wire

// >>> i2c_register_control_slave.sv
`timescale 1ns/100ps
`default_nettype none

module i2c_register_control_slave
   import i2c_ctrl_pkg::*;
#(
   parameter int REGS = REG_COUNT
) (
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   input  wire logic       proto_select,
   input  wire logic       scl_in,
   output var  logic       scl_out,
   output var  logic       scl_oe,
   input  wire logic       sda_in,
   output var  logic       sda_out,
   output var  logic       sda_oe,
   output var  logic       two_wire_active,
   output var  logic       gc_enable,
   output var  logic       busy
);

   logic [2:0]   pins_sync;
   logic         scl_s;
   logic         sda_s;
   logic         sel_s;
   logic         scl_d;
   logic         sda_d;
   logic         scl_rise;
   logic         scl_fall;
   logic         start_det;
   logic         stop_det;
   slave_state_e state;
   logic [3:0]   bit_cnt;
   logic [7:0]   shift_in;
   logic [7:0]   shift_out;
   logic         first_byte;
   logic         sampled_bit;
   logic [6:0]   reg_ptr;
   logic [7:0]   regs [REGS];
   logic         addr_match;
   logic         port_en;

   // ***********************************************
   // Pin sampling and condition detection
   // ***********************************************
   pin_sync #(
      .WIDTH (3)
   ) u_sync (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .async_in ({proto_select, scl_in, sda_in}),
      .sync_out (pins_sync)
   );

   assign sel_s = pins_sync[2];
   assign scl_s = pins_sync[1];
   assign sda_s = pins_sync[0];

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign port_en   = !sel_s;
   assign scl_rise  = port_en && scl_s && !scl_d;
   assign scl_fall  = port_en && !scl_s && scl_d;
   assign start_det = port_en && scl_s && scl_d && sda_d && !sda_s;
   assign stop_det  = port_en && scl_s && scl_d && !sda_d && sda_s;

   assign two_wire_active = port_en;
   assign busy            = (state != ST_IDLE);
   assign gc_enable       = regs[GC_CTRL_REG][GC_ENABLE_BIT];

   // Clock line is never driven by this slave
   assign scl_out = 1'b0;
   assign scl_oe  = 1'b0;

   assign addr_match = (shift_in[7:1] == TARGET_ADDR) ||
                       (gc_enable && shift_in[7:1] == GENERAL_CALL);

   // ***********************************************
   // Bit sampling on clock high
   // ***********************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sampled_bit <= 1'b1;
      end else if (scl_rise) begin
         sampled_bit <= sda_s;
      end
   end

   // ***********************************************
   // Transaction state machine
   // ***********************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state    <= ST_IDLE;
         bit_cnt  <= 4'h0;
         shift_in <= 8'h00;
      end else if (!port_en || stop_det) begin
         state <= ST_IDLE;
      end else if (start_det) begin
         state    <= ST_ADDR;
         bit_cnt  <= 4'h0;
      end else if (scl_rise && (state == ST_ADDR || state == ST_WRITE)) begin
         shift_in <= {shift_in[6:0], sda_s};
         // Address bits counted on rises, the fall after START is no bit
         if (state == ST_ADDR) begin
            bit_cnt <= bit_cnt + 4'h1;
         end
      end else if (scl_fall) begin
         unique case (state)
            ST_IDLE, ST_IGNORE: begin
               bit_cnt <= 4'h0;
            end
            ST_ADDR: begin
               if (bit_cnt == ACK_SLOT) begin
                  state <= addr_match ? ST_ADDR_ACK : ST_IGNORE;
               end
            end
            ST_WRITE: begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == ACK_SLOT - 4'h1) begin
                  state <= ST_WRITE_ACK;
               end
            end
            ST_READ: begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == ACK_SLOT - 4'h1) begin
                  state <= ST_READ_ACK;
               end
            end
            ST_ADDR_ACK: begin
               bit_cnt <= 4'h0;
               state   <= shift_in[0] ? ST_READ : ST_WRITE;
            end
            ST_WRITE_ACK: begin
               bit_cnt <= 4'h0;
               state   <= ST_WRITE;
            end
            ST_READ_ACK: begin
               bit_cnt <= 4'h0;
               state   <= sampled_bit ? ST_IGNORE : ST_READ;
            end
         endcase
      end
   end

   // ***********************************************
   // Pointer and register file
   // ***********************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         first_byte <= 1'b0;
         reg_ptr    <= PTR_RESET;
         for (int i = 0; i < REGS; i++) begin
            regs[i] <= REG_RESET;
         end
      end else if (scl_fall && port_en) begin
         if (state == ST_ADDR_ACK) begin
            first_byte <= !shift_in[0];
         end else if (state == ST_WRITE_ACK) begin
            first_byte <= 1'b0;
            if (first_byte) begin
               reg_ptr <= shift_in[6:0];
            end else begin
               regs[reg_ptr] <= shift_in;
               reg_ptr       <= reg_ptr + 7'h1;
            end
         end else if (state == ST_READ_ACK && !sampled_bit) begin
            reg_ptr <= reg_ptr + 7'h1;
         end else if (state == ST_ADDR_ACK) begin
            first_byte <= 1'b0;
         end
      end
   end

   // ***********************************************
   // Read shifter
   // ***********************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         shift_out <= 8'hff;
      end else if (scl_fall) begin
         if (state == ST_ADDR_ACK) begin
            shift_out <= regs[reg_ptr];
         end else if (state == ST_READ_ACK) begin
            shift_out <= regs[reg_ptr + 7'h1];
         end else if (state == ST_READ && bit_cnt != ACK_SLOT - 4'h1) begin
            shift_out <= {shift_out[6:0], 1'b1};
         end
      end
   end

   // ***********************************************
   // Open-drain data driver
   // ***********************************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sda_oe <= 1'b0;
      end else if (!port_en || stop_det || start_det) begin
         sda_oe <= 1'b0;
      end else if (scl_fall) begin
         if (state == ST_ADDR && bit_cnt == ACK_SLOT) begin
            sda_oe <= addr_match;
         end else if (state == ST_WRITE && bit_cnt == ACK_SLOT - 4'h1) begin
            sda_oe <= 1'b1;
         end else if (state == ST_ADDR_ACK) begin
            sda_oe <= shift_in[0] && !regs[reg_ptr][7];
         end else if (state == ST_READ_ACK) begin
            sda_oe <= !sampled_bit && !regs[reg_ptr + 7'h1][7];
         end else if (state == ST_READ && bit_cnt != ACK_SLOT - 4'h1) begin
            sda_oe <= !shift_out[6];
         end else begin
            sda_oe <= 1'b0;
         end
      end
   end

   assign sda_out = 1'b0;

endmodule : i2c_register_control_slave

`default_nettype wire

// >>> i2c_register_control_slave_properties.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_register_control_slave_properties
   import i2c_ctrl_pkg::*;
#(
   parameter int REGS = REG_COUNT
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic proto_select,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic two_wire_active,
   input wire logic gc_enable,
   input wire logic busy
);
   // ****
   // Bus conditions
   // ****
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   sequence start_seq;
      two_wire_active && scl_in && $fell(sda_in) ##1 scl_in;
   endsequence
   sequence stop_seq;
      scl_in && $rose(sda_in) ##1 scl_in;
   endsequence
   a_clock_never_driven: assert property (!scl_oe && !scl_out)
      else $error("clock line driven");
   a_data_only_low: assert property (!sda_out) else $error("data driven high");
   a_strap_blocks_port: assert property ($rose(proto_select) |-> ##[1:4] !two_wire_active)
      else $error("strap ignored");
   a_strap_silences_bus: assert property (!two_wire_active [*3] |-> !sda_oe)
      else $error("pull while port off");
   a_idle_never_pulls: assert property (sda_oe |-> busy) else $error("pull when idle");
   a_pull_while_low: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("data changed with clock high");
   a_start_wakes: assert property (start_seq |-> ##[1:6] busy) else $error("start missed");
   a_stop_ends_txn: assert property (stop_seq |-> ##[1:6] !busy) else $error("stop missed");
   a_gc_reset_clear: assert property ($rose(resetn) |-> !gc_enable)
      else $error("call enable set after reset");
   a_gc_needs_write: assert property (!busy ##1 !busy |-> $stable(gc_enable))
      else $error("call enable moved while idle");
endmodule : i2c_register_control_slave_properties
`default_nettype wire

// >>> i2c_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
   input  wire logic ref_clk,
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   output var  logic scl,
   output var  logic sda
);
   // ****
   // Master side of the open-drain pair
   // ****
   logic scl_r = 1'b1;
   logic pull = 1'b0;
   assign scl = scl_r & ~scl_oe;
   assign sda = ~(sda_oe | pull);
   task automatic clk_bit(input logic b, output logic r);
      pull <= ~b;
      repeat (3) @(posedge ref_clk);
      scl_r <= 1'b1;
      repeat (2) @(posedge ref_clk);
      r = sda;
      repeat (2) @(posedge ref_clk);
      scl_r <= 1'b0;
      @(posedge ref_clk);
   endtask : clk_bit
   task automatic xfer(input logic [7:0] dout, input logic mack,
                       output logic [7:0] din, output logic sack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(dout[i], r);
         din[i] = r;
      end
      clk_bit(mack, r);
      sack = ~r;
   endtask : xfer
   // First low gives START, first high gives STOP
   task automatic cond(input logic first);
      pull <= first;
      repeat (6) @(posedge ref_clk);
      scl_r <= 1'b1;
      repeat (4) @(posedge ref_clk);
      pull <= ~first;
      repeat (4) @(posedge ref_clk);
      scl_r <= first;
      @(posedge ref_clk);
   endtask : cond
endmodule : i2c_host_model
`default_nettype wire

// >>> i2c_register_control_slave_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_register_control_slave_tb_top import i2c_ctrl_pkg::*;;
   logic ref_clk, resetn, proto_select, scl_in, sda_in, scl_out, scl_oe;
   logic sda_out, sda_oe, two_wire_active, gc_enable, busy, ack;
   logic [7:0] shadow [REG_COUNT];
   logic [7:0] d;
   logic [6:0] p;
   int num_errors = 0;
   int cmp_count = 0;
   int n;
   i2c_register_control_slave i_i2c_register_control_slave (.ref_clk, .resetn, .proto_select,
      .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .two_wire_active, .gc_enable, .busy);
   i2c_host_model i_i2c_host_model (.ref_clk, .scl_oe, .sda_oe, .scl(scl_in), .sda(sda_in));
   // ****
   // Checks and transactions
   // ****
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict;
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   function automatic logic [7:0] exp_reg(input logic [6:0] ptr, input int i);
      return shadow[ptr + 7'(i)];
   endfunction : exp_reg
   task automatic open_txn(input logic [7:0] a, input logic exp);
      i_i2c_host_model.cond(1'b0);
      i_i2c_host_model.xfer(a, 1'b1, d, ack);
      chk(ack, exp);
   endtask : open_txn
   task automatic finish_txn;
      i_i2c_host_model.cond(1'b1);
      for (int i = 0; i < 8 && busy !== 1'b0; i++) begin
         @(posedge ref_clk);
      end
      chk(busy, 1'b0);
   endtask : finish_txn
   task automatic set_ptr(input logic [6:0] ptr);
      open_txn({TARGET_ADDR, 1'b0}, 1'b1);
      i_i2c_host_model.xfer({1'b0, ptr}, 1'b1, d, ack);
      chk(ack, 1'b1);
   endtask : set_ptr
   task automatic wr(input logic [6:0] ptr, input int cnt, input logic [7:0] orm);
      logic [7:0] v;
      set_ptr(ptr);
      for (int i = 0; i < cnt; i++) begin
         v = 8'($urandom) | orm;
         i_i2c_host_model.xfer(v, 1'b1, d, ack);
         chk(ack, 1'b1);
         shadow[ptr + 7'(i)] = v;
      end
      finish_txn();
      chk(gc_enable, shadow[GC_CTRL_REG][GC_ENABLE_BIT]);
   endtask : wr
   task automatic rd(input logic [6:0] ptr, input int cnt);
      set_ptr(ptr);
      open_txn({TARGET_ADDR, 1'b1}, 1'b1);
      for (int i = 0; i < cnt; i++) begin
         i_i2c_host_model.xfer(8'hff, i == cnt - 1, d, ack);
         chk(d, exp_reg(ptr, i));
      end
      repeat (5) @(posedge ref_clk);
      chk(sda_oe, 1'b0);
      finish_txn();
   endtask : rd
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      give_verdict();
   end
   initial begin
      resetn = 1'b0;
      proto_select = 1'b0;
      foreach (shadow[i]) begin
         shadow[i] = REG_RESET;
      end
      void'($urandom(57005));
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk(two_wire_active, 1'b1);
      chk(gc_enable, 1'b0);
      open_txn(8'h00, 1'b0);
      finish_txn();
      for (int k = 0; k < 4; k++) begin
         p = (k == 0) ? 7'h7f : 7'($urandom);
         n = (k == 0) ? 2 : 1 + $urandom % 3;
         wr(p, n, 8'h00);
         rd(p, n);
      end
      wr(GC_CTRL_REG, 1, 8'h20);
      open_txn(8'h00, 1'b1);
      finish_txn();
      for (int k = 0; k < 3; k++) begin
         p = 7'($urandom);
         p = (p == TARGET_ADDR || p == GENERAL_CALL) ? 7'h55 : p;
         open_txn({p, 1'b0}, 1'b0);
         i_i2c_host_model.xfer(8'($urandom), 1'b1, d, ack);
         chk(ack, 1'b0);
         finish_txn();
      end
      proto_select <= 1'b1;
      repeat (6) @(posedge ref_clk);
      chk(two_wire_active, 1'b0);
      open_txn({TARGET_ADDR, 1'b0}, 1'b0);
      finish_txn();
      give_verdict();
   end
endmodule : i2c_register_control_slave_tb_top
bind i2c_register_control_slave i2c_register_control_slave_properties #(.REGS(REGS))
   i_i2c_register_control_slave_properties (.ref_clk, .resetn, .proto_select, .scl_in,
   .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .two_wire_active, .gc_enable, .busy);
`default_nettype wire
